//--- rtl/rcss_pkg.sv
// rcss_pkg: constants and types for the capture/strobe status block.
// assumes a 32-bit classic wishbone slave, word-aligned registers.
package rcss_pkg;

    // clocking
    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned SLOW_HZ     = 32_768;
    localparam int unsigned SLOW_DIV    = CLK_HZ / SLOW_HZ;
    localparam logic [9:0]  SLOW_DIV_M1 = 10'(SLOW_DIV - 1);

    // register byte offsets
    localparam logic [7:0] OFS_CAP_STATUS   = 8'h00;
    localparam logic [7:0] OFS_STB_STATUS   = 8'h04;
    localparam logic [7:0] OFS_CHAN0_VALUE  = 8'h08;
    localparam logic [7:0] OFS_CHAN2_VALUE  = 8'h0C;
    localparam logic [7:0] OFS_CHAN3_VALUE  = 8'h10;
    localparam logic [7:0] OFS_CHAN4_VALUE  = 8'h14;
    localparam logic [7:0] OFS_SNAP_LOW     = 8'h18;
    localparam logic [7:0] OFS_SNAP_MID     = 8'h1C;
    localparam logic [7:0] OFS_SNAP_HIGH    = 8'h20;
    localparam logic [7:0] OFS_STB_CONFIG   = 8'h24;
    localparam logic [7:0] OFS_SNAP_CTRL    = 8'h28;

    // capture_unread_status fields
    localparam int unsigned BIT_CHAN0_UNR   = 0;
    localparam int unsigned BIT_CHAN2_UNR   = 2;
    localparam int unsigned BIT_CHAN3_UNR   = 3;
    localparam int unsigned BIT_CHAN4_UNR   = 4;
    localparam int unsigned BIT_SNAP_SRC    = 5;

    // strobe_sample_status fields
    localparam int unsigned BIT_STB_OUT_LO  = 12;
    localparam int unsigned BIT_MATCH3      = 11;
    localparam int unsigned BIT_SMP3_LO     = 8;

    // strobe_sample_config fields
    localparam int unsigned BIT_EXP3_LO     = 0;
    localparam int unsigned BIT_PTRN3_LO    = 4;

    // reset values
    localparam logic [15:0] RST_CAP_STATUS  = 16'h0000;
    localparam logic [15:0] RST_STB_STATUS  = 16'h0000;
    localparam logic [31:0] RST_READ_ZERO   = 32'h0000_0000;

    // channel 3 pattern modes
    typedef enum logic [1:0] {
        RCSS_PTRN_EQ_EXP,
        RCSS_PTRN_NE_EXP,
        RCSS_PTRN_CHANGED,
        RCSS_PTRN_STEADY
    } rcss_ptrn_e;

    typedef struct packed {
        rcss_ptrn_e  mode;
        logic [2:0]  expected;
    } rcss_stb_cfg_s;

    typedef struct packed {
        logic        src_is_capture;
        logic [47:0] value;
    } rcss_snap_s;

endpackage

//--- rtl/rcss_top.sv
// rcss_top: capture unread flags, snapshot source, strobe status.
// assumes events and samples synchronous to clk_i; the always-on
// side is modelled by a 32 kHz enable pulse from a divider.
`timescale 1ns/1ps

// Operation
// - source bit 0 means software snapshot
// - source bit 1 means channel 0 capture
// - bit 4 sticky: channel 4 unread
// - bit 3 sticky: channel 3 unread
// - bit 2 sticky: channel 2 unread
// - bit 0 sticky: channel 0 unread
// - basic instance: status reads reset value
// - strobe outputs 4..1 at bits 15:12
// - bit 11 set on channel 3 match
// - write 1 clears match, 0 keeps
// - latest channel 3 sample in 10:8
module rcss_top #(
    parameter bit EXTENDED = 1'b1
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // counter and capture events (index = channel)
    input  wire logic [47:0] count_i,
    input  wire logic [4:0]  capture_evt_i,
    // strobe channels
    input  wire logic [3:0]  strobe_out_i,
    input  wire logic [2:0]  strobe3_sample_i,
    input  wire logic        strobe3_sample_vld_i
);

    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    // assert at once, release only on a clock edge
    assign rst_n = rst_sync_r[1];

    // slow tick divider
    // fraction dropped: 762 clocks a tick, so the tick runs slightly fast
    logic [9:0] div_cnt_r;
    logic       tick_r;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 10'h000;
            tick_r    <= 1'b0;
        end else if (div_cnt_r == rcss_pkg::SLOW_DIV_M1) begin
            div_cnt_r <= 10'h000;
            tick_r    <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 10'h001;
            tick_r    <= 1'b0;
        end
    end

    function automatic logic ptrn_match(input rcss_pkg::rcss_ptrn_e mode,
                                        input logic [2:0] smp,
                                        input logic [2:0] prev,
                                        input logic [2:0] expv);
        case (mode)
            rcss_pkg::RCSS_PTRN_EQ_EXP:  ptrn_match = (smp == expv);
            rcss_pkg::RCSS_PTRN_NE_EXP:  ptrn_match = (smp != expv);
            rcss_pkg::RCSS_PTRN_CHANGED: ptrn_match = (smp != prev);
            rcss_pkg::RCSS_PTRN_STEADY:  ptrn_match = (smp == prev);
            default:                     ptrn_match = 1'b0;
        endcase
    endfunction

    // exact byte address; unaligned offsets decode as unmapped
    function automatic logic adr_hit(input logic [7:0] adr,
                                     input logic [7:0] ofs);
        adr_hit = (adr == ofs);
    endfunction

    // bus decode; reads launch on the request edge, writes on the ack edge
    logic req;
    logic wr;
    logic rd;
    logic wr_snap;
    logic wr_match_clr;
    logic wr_cfg;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    assign rd  = req & ~wb_we_i;

    // a write only counts when its byte lane is enabled
    assign wr_snap      = wr & adr_hit(wb_adr_i, rcss_pkg::OFS_SNAP_CTRL)
                          & wb_sel_i[0] & wb_dat_i[0];
    assign wr_match_clr = wr & adr_hit(wb_adr_i, rcss_pkg::OFS_STB_STATUS)
                          & wb_sel_i[1] & wb_dat_i[rcss_pkg::BIT_MATCH3];
    assign wr_cfg       = wr & adr_hit(wb_adr_i, rcss_pkg::OFS_STB_CONFIG)
                          & wb_sel_i[0];

    // events wait for the slow tick; a pulse is never lost
    logic [4:0] evt_pend_r;
    logic [4:0] clr_pend_r;
    logic       snap_req_pend_r;
    logic       smp_pend_r;
    logic [2:0] smp_hold_r;
    logic       match_clr_pend_r;
    logic [4:0] rd_clr;

    // a read clears on the request edge; a new set still wins at the tick
    always_comb begin
        rd_clr = 5'b00000;
        if (rd) begin
            case (wb_adr_i)
                rcss_pkg::OFS_CHAN0_VALUE: rd_clr[0] = 1'b1;
                rcss_pkg::OFS_CHAN2_VALUE: rd_clr[2] = 1'b1;
                rcss_pkg::OFS_CHAN3_VALUE: rd_clr[3] = 1'b1;
                rcss_pkg::OFS_CHAN4_VALUE: rd_clr[4] = 1'b1;
                default:                   rd_clr    = 5'b00000;
            endcase
        end
    end

    // an event in the tick cycle itself waits for the next tick
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            evt_pend_r <= 5'b00000;
        end else if (tick_r) begin
            evt_pend_r <= capture_evt_i;
        end else begin
            evt_pend_r <= evt_pend_r | capture_evt_i;
        end
    end

    // read-clears cross into the slow side at the next tick
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            clr_pend_r <= 5'b00000;
        end else if (tick_r) begin
            clr_pend_r <= rd_clr;
        end else begin
            clr_pend_r <= clr_pend_r | rd_clr;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            snap_req_pend_r <= 1'b0;
        end else begin
            if (tick_r) begin
                snap_req_pend_r <= 1'b0;
            end
            if (wr_snap) begin
                snap_req_pend_r <= 1'b1;
            end
        end
    end

    // only the last sample before a tick is kept
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            smp_pend_r <= 1'b0;
            smp_hold_r <= 3'h0;
        end else begin
            if (tick_r) begin
                smp_pend_r <= 1'b0;
            end
            if (strobe3_sample_vld_i) begin
                smp_pend_r <= 1'b1;
                smp_hold_r <= strobe3_sample_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            match_clr_pend_r <= 1'b0;
        end else begin
            if (tick_r) begin
                match_clr_pend_r <= 1'b0;
            end
            if (wr_match_clr) begin
                match_clr_pend_r <= 1'b1;
            end
        end
    end

    // slow side state
    logic [4:0]            unread_r;
    logic [31:0]           chan_val_r [5];
    rcss_pkg::rcss_snap_s  snap_r;
    logic [2:0]            smp3_r;
    logic                  match3_r;
    logic [3:0]            stb_out_r;
    rcss_pkg::rcss_stb_cfg_s cfg_r;

    // set beats clear when both land on one tick
    // channel 1 has no flag; its slot keeps indices equal to channels
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            unread_r <= 5'b00000;
        end else if (tick_r) begin
            unread_r <= ((unread_r & ~clr_pend_r) | evt_pend_r)
                        & 5'b11101;
        end
    end

    // value is the count at the tick, not at the event itself
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 5; i++) begin
                chan_val_r[i] <= 32'h0000_0000;
            end
        end else if (tick_r) begin
            for (int i = 0; i < 5; i++) begin
                if (evt_pend_r[i]) begin
                    chan_val_r[i] <= count_i[31:0];
                end
            end
        end
    end

    // capture wins over a software request on the same tick
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            snap_r <= '0;
        end else if (tick_r) begin
            if (evt_pend_r[0]) begin
                snap_r.value          <= count_i;
                snap_r.src_is_capture <= 1'b1;
            end else if (snap_req_pend_r) begin
                snap_r.value          <= count_i;
                snap_r.src_is_capture <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            smp3_r <= 3'h0;
        end else if (tick_r && smp_pend_r) begin
            smp3_r <= smp_hold_r;
        end
    end

    // compared against the sample shown before this tick
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            match3_r <= 1'b0;
        end else if (tick_r) begin
            if (smp_pend_r && ptrn_match(cfg_r.mode, smp_hold_r, smp3_r,
                                         cfg_r.expected)) begin
                match3_r <= 1'b1;
            end else if (match_clr_pend_r) begin
                match3_r <= 1'b0;
            end
        end
    end

    // strobe states are not tick gated, one clock late
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            stb_out_r <= 4'h0;
        end else begin
            stb_out_r <= strobe_out_i;
        end
    end

    // config acts at once; no posting to the slow side
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= '0;
        end else if (wr_cfg) begin
            cfg_r.expected <= wb_dat_i[rcss_pkg::BIT_EXP3_LO +: 3];
            cfg_r.mode <= rcss_pkg::rcss_ptrn_e'(
                          wb_dat_i[rcss_pkg::BIT_PTRN3_LO +: 2]);
        end
    end

    // read mux
    logic [15:0] cap_status;
    logic [15:0] stb_status;
    logic [31:0] rd_data;

    always_comb begin
        cap_status = rcss_pkg::RST_CAP_STATUS;
        stb_status = rcss_pkg::RST_STB_STATUS;
        // basic instance: both status words hold their reset value
        if (EXTENDED) begin
            cap_status[4:0] = unread_r;
            cap_status[rcss_pkg::BIT_SNAP_SRC] = snap_r.src_is_capture;
            stb_status[rcss_pkg::BIT_STB_OUT_LO +: 4] = stb_out_r;
            stb_status[rcss_pkg::BIT_MATCH3] = match3_r;
            stb_status[rcss_pkg::BIT_SMP3_LO +: 3] = smp3_r;
        end
    end

    always_comb begin
        case (wb_adr_i)
            rcss_pkg::OFS_CAP_STATUS:  rd_data = {16'h0000, cap_status};
            rcss_pkg::OFS_STB_STATUS:  rd_data = {16'h0000, stb_status};
            rcss_pkg::OFS_CHAN0_VALUE: rd_data = chan_val_r[0];
            rcss_pkg::OFS_CHAN2_VALUE: rd_data = chan_val_r[2];
            rcss_pkg::OFS_CHAN3_VALUE: rd_data = chan_val_r[3];
            rcss_pkg::OFS_CHAN4_VALUE: rd_data = chan_val_r[4];
            rcss_pkg::OFS_SNAP_LOW:    rd_data = {16'h0000,
                                                  snap_r.value[15:0]};
            rcss_pkg::OFS_SNAP_MID:    rd_data = {16'h0000,
                                                  snap_r.value[31:16]};
            rcss_pkg::OFS_SNAP_HIGH:   rd_data = {16'h0000,
                                                  snap_r.value[47:32]};
            rcss_pkg::OFS_STB_CONFIG:  rd_data = {26'h0, cfg_r.mode,
                                                  1'b0, cfg_r.expected};
            default:                   rd_data = rcss_pkg::RST_READ_ZERO;
        endcase
    end

    // single-wait-state slave; unmapped reads as zero, writes dropped
    // read data stands until the next read, so a slow master still sees it
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                wb_dat_o <= rd_data;
            end
        end
    end

endmodule // rcss_top

//--- tb/rcss_monitor.sv
// rcss_monitor: bus-side checks of the capture/strobe status block.
// assumes it is bound into every rcss_top and sees only its ports.
`timescale 1ns/1ps
module rcss_monitor #(
    parameter bit EXTENDED = 1'b1
) (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // events and strobes
    input wire logic [47:0] count_i,
    input wire logic [4:0]  capture_evt_i,
    input wire logic [3:0]  strobe_out_i,
    input wire logic [2:0]  strobe3_sample_i,
    input wire logic        strobe3_sample_vld_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // causes seen since reset; a flag without its cause is a fault
    logic [5:0] seen_r;
    logic       sw_r;
    logic       rd_cap;
    logic       rd_stb;
    logic       rd_snap;
    assign rd_cap  = wb_ack_o && !wb_we_i
                     && wb_adr_i == rcss_pkg::OFS_CAP_STATUS;
    assign rd_stb  = wb_ack_o && !wb_we_i
                     && wb_adr_i == rcss_pkg::OFS_STB_STATUS;
    assign rd_snap = wb_ack_o && !wb_we_i
                     && wb_adr_i == rcss_pkg::OFS_SNAP_LOW;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) seen_r <= 6'h00;
        else seen_r <= seen_r | {strobe3_sample_vld_i, capture_evt_i};
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) sw_r <= 1'b0;
        else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_dat_i[0]
                 && wb_adr_i == rcss_pkg::OFS_SNAP_CTRL) sw_r <= 1'b1;
    end
    AST_STB_OUT:
        assert property ((rd_stb && $stable(strobe_out_i)
            && $past(strobe_out_i) == $past(strobe_out_i, 2))
            |-> wb_dat_o[15:12] == (EXTENDED ? strobe_out_i : 4'h0))
        else $error("strobe output bits wrong");
    AST_BASIC_ZERO:
        assert property ((wb_ack_o && !wb_we_i && !EXTENDED
            && wb_adr_i[7:3] == 5'h00) |-> wb_dat_o == 32'h0000_0000)
        else $error("basic status not at reset value");
    AST_CAP_RSVD:
        assert property (rd_cap |-> wb_dat_o[31:6] == 26'h0 && !wb_dat_o[1])
        else $error("capture status spare bits set");
    AST_UNR_CAUSE:
        assert property (rd_cap |-> (wb_dat_o[4:0] & ~seen_r[4:0]) == 5'h00)
        else $error("unread flag without capture");
    AST_SRC_CAP:
        assert property (rd_cap && wb_dat_o[5] |-> seen_r[0])
        else $error("capture source without channel 0 event");
    AST_SRC_SW:
        assert property (rd_snap && wb_dat_o != 32'h0 |-> sw_r || seen_r[0])
        else $error("snapshot without any request");
    AST_MATCH_CAUSE:
        assert property (rd_stb && wb_dat_o[11] |-> seen_r[5])
        else $error("match flag without sample");
    AST_SAMPLE:
        assert property (rd_stb && !seen_r[5] |-> wb_dat_o[11:8] == 4'h0)
        else $error("sample field without sample");
endmodule // rcss_monitor

bind rcss_top rcss_monitor #(.EXTENDED(EXTENDED)) i_mon (
    .clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .count_i, .capture_evt_i,
    .strobe_out_i, .strobe3_sample_i, .strobe3_sample_vld_i
);

//--- tb/tb.sv
// tb: self-checking bench for the capture/strobe status block.
// assumes one-cycle wishbone ack and flag updates within 800 cycles.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [4:0] evt;
        logic       sw;
        logic [5:0] cfg;
        logic [2:0] smp;
        logic [3:0] stb;
        logic [5:0] cap;
        logic       mt;
    } rcss_row_s;
    // events, sw snapshot, config, sample, strobes, expected status
    localparam rcss_row_s ROWS [5] = '{
        '{5'h01, 1'b0, 6'h05, 3'h5, 4'hA, 6'h21, 1'b1},
        '{5'h14, 1'b1, 6'h15, 3'h5, 4'h5, 6'h14, 1'b0},
        '{5'h08, 1'b0, 6'h20, 3'h3, 4'h3, 6'h08, 1'b1},
        '{5'h00, 1'b0, 6'h30, 3'h3, 4'hC, 6'h00, 1'b1},
        '{5'h03, 1'b1, 6'h07, 3'h6, 4'hF, 6'h21, 1'b0}};
    logic        clk_i                = 1'b0;
    logic        reset_n_i            = 1'b0;
    logic        wb_cyc_i             = 1'b0;
    logic        wb_stb_i             = 1'b0;
    logic        wb_we_i              = 1'b0;
    logic [7:0]  wb_adr_i             = 8'h00;
    logic [3:0]  wb_sel_i             = 4'h0;
    logic [31:0] wb_dat_i             = 32'h0;
    logic [47:0] count_i              = 48'h0;
    logic [4:0]  capture_evt_i        = 5'h00;
    logic [3:0]  strobe_out_i         = 4'h0;
    logic [2:0]  strobe3_sample_i     = 3'h0;
    logic        strobe3_sample_vld_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic [31:0] dat_b;
    logic [31:0] rdat;
    logic        wb_ack_o;
    int          error_cnt            = 0;
    int          checks               = 0;

    rcss_top i_rcss_top (.clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .count_i, .capture_evt_i, .strobe_out_i, .strobe3_sample_i,
        .strobe3_sample_vld_i);
    // basic instance shares the bus; only its read data is watched
    rcss_top #(.EXTENDED(1'b0)) i_rcss_top_basic (.clk_i, .reset_n_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o(dat_b), .wb_ack_o(), .count_i, .capture_evt_i,
        .strobe_out_i, .strobe3_sample_i, .strobe3_sample_vld_i);

    initial forever #20 clk_i = ~clk_i;

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            report_and_stop();
        end
        rdat = wb_dat_o;
        if (!w && a[7:3] == 5'h00) chk("basic", 32'h0, dat_b);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        bus(a, 1'b0, 32'h0, 4'hF);
        chk(nm, e, rdat);
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        foreach (ROWS[i]) begin
            strobe_out_i <= ROWS[i].stb;
            count_i      <= 48'h3333_2222_1100 | 48'(i);
            bus(rcss_pkg::OFS_STB_CONFIG, 1'b1, 32'(ROWS[i].cfg), 4'h1);
            repeat (800) @(posedge clk_i);
            if (ROWS[i].sw) bus(rcss_pkg::OFS_SNAP_CTRL, 1'b1, 32'h1, 4'h1);
            capture_evt_i        <= ROWS[i].evt;
            strobe3_sample_i     <= ROWS[i].smp;
            strobe3_sample_vld_i <= 1'b1;
            @(posedge clk_i);
            capture_evt_i        <= 5'h00;
            strobe3_sample_vld_i <= 1'b0;
            repeat (800) @(posedge clk_i);
            rd(rcss_pkg::OFS_CAP_STATUS, 32'(ROWS[i].cap), "cap");
            rd(rcss_pkg::OFS_STB_STATUS, {16'h0, ROWS[i].stb,
               ROWS[i].mt, ROWS[i].smp, 8'h00}, "stb");
            rd(rcss_pkg::OFS_STB_CONFIG, 32'(ROWS[i].cfg), "cfg");
            if (ROWS[i].sw || ROWS[i].evt[0]) begin
                rd(rcss_pkg::OFS_SNAP_LOW, 32'h1100 | 32'(i),
                   "snap");
                rd(rcss_pkg::OFS_SNAP_MID, 32'h2222, "snap mid");
                rd(rcss_pkg::OFS_SNAP_HIGH, 32'h3333, "snap hi");
            end
            // reading each value clears its unread flag at the next tick
            for (int k = 0; k < 4; k++) begin
                bus(8'h08 + 8'(4 * k), 1'b0, 32'h0, 4'hF);
                // channels 0, 2, 3, 4 sit in consecutive words
                if (ROWS[i].evt[k + int'(k > 0)])
                    chk("value", 32'h2222_1100 | 32'(i), rdat);
            end
            bus(rcss_pkg::OFS_STB_STATUS, 1'b1, 32'h800, 4'h2);
            repeat (800) @(posedge clk_i);
            rd(rcss_pkg::OFS_CAP_STATUS,
               32'(ROWS[i].cap & 6'h20), "cap clr");
            rd(rcss_pkg::OFS_STB_STATUS, {16'h0, ROWS[i].stb,
               1'b0, ROWS[i].smp, 8'h00}, "stb clr");
        end
        // new match, then writes of 0 and to read-only bits
        strobe3_sample_i     <= 3'h7;
        strobe3_sample_vld_i <= 1'b1;
        @(posedge clk_i);
        strobe3_sample_vld_i <= 1'b0;
        bus(rcss_pkg::OFS_STB_STATUS, 1'b1, 32'hFFFF_F7FF, 4'hF);
        bus(rcss_pkg::OFS_CAP_STATUS, 1'b1, 32'hFFFF_FFFF, 4'hF);
        bus(8'h3C, 1'b1, 32'hFFFF_FFFF, 4'hF);
        repeat (800) @(posedge clk_i);
        rd(rcss_pkg::OFS_CAP_STATUS, 32'h20, "cap ro");
        rd(rcss_pkg::OFS_STB_STATUS, 32'hFF00, "stb ro");
        rd(8'h3C, 32'h0, "unmapped");
        // second reset in mid-run must clear every flag
        strobe_out_i <= 4'h0;
        reset_n_i    <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(rcss_pkg::OFS_CAP_STATUS, 32'h0, "cap rst");
        rd(rcss_pkg::OFS_STB_STATUS, 32'h0, "stb rst");
        report_and_stop();
    end
endmodule // tb
